// ### common/acsp_pkg.sv
// Constants for the acceleration sensor serial port controller
package acsp_pkg;
	localparam int MCLK_HZ = 25000000;
	// Half period of the generated serial clock, in mclk cycles
	localparam int SCK_HALF = 4;
	localparam logic [7:0] SCK_HALF_M1 = 8'(SCK_HALF - 1);
	localparam int FRAME_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam int ADDR_BITS = 7;
	localparam int DIR_POS = 7;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	localparam logic [6:0] ADDR_SPI_CFG = 7'h34;
	localparam logic [6:0] ADDR_FIFO_DATA = 7'h3f;
	localparam int THREE_WIRE_POS = 0;
	// Idle between writes, in ns
	localparam int WIDLE_NORMAL_NS = 2000;
	localparam int WIDLE_SUSPEND_NS = 450000;
	localparam int WIDLE_NORMAL_CYC = (WIDLE_NORMAL_NS * 25 + 999) / 1000;
	localparam int WIDLE_SUSPEND_CYC = (WIDLE_SUSPEND_NS * 25 + 999) / 1000;
	localparam int IDLE_W = 15;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W = 8;
	localparam logic [IDLE_W-1:0] IDLE_ZERO = 15'h0000;
	localparam logic [4:0] BIT_ZERO = 5'h00;
	localparam logic [4:0] BYTE_LAST = 5'h07;
	localparam logic [4:0] FRAME_LAST = 5'h0f;
endpackage

// ### rtl/acsp_fifo.sv
// Small first-in first-out buffer in flip-flops
`timescale 1ns/1ps
`default_nettype none
module acsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rp_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wp_q] <= in_data;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ### rtl/acsp_master.sv
// Serial port master driving the acceleration sensor
// Notes on behaviour
// - Start in 4-wire; switch to 3-wire after writing one to 0x34 bit 0.
// - A single access is one 16-bit frame: control byte then data.
// - Chip select low opens a frame, high closes it; we make the clock.
// - Change output on falling clock edge, sample on rising edge (we sample at end of high phase).
// - First control bit is direction: 0 write, 1 read.
// - Next seven bits are the register address, most significant first.
// - Bits eight to fifteen carry the data byte.
// - Bursts send one address, keep chip select low, keep clocking (only reads burst here; cmd_len is ignored on writes).
// - Wait 2 us between writes, or 450 us in suspend modes.
// - 3-wire uses the same frame format and edges as 4-wire.
`timescale 1ns/1ps
`default_nettype none
module acsp_master #(
	parameter int WIDLE_NORMAL = acsp_pkg::WIDLE_NORMAL_CYC,
	parameter int WIDLE_SUSPEND = acsp_pkg::WIDLE_SUSPEND_CYC
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [6:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic [4:0] cmd_len,
	input wire logic cpol,
	input wire logic suspend_mode,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [7:0] rd_data,
	output logic three_wire,
	output logic chip_select_n,
	output logic sck,
	output logic sdi_out,
	output logic sdi_oe,
	input wire logic sdi_in,
	input wire logic sdo_in
);
	import acsp_pkg::*;
	// ************************************************************
	// Reset and input synchronisers
	// ************************************************************
	logic rst_a_q;
	logic rst_n;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_a_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_a_q <= 1'b1;
			rst_n <= rst_a_q;
		end
	end
	logic sdo_m_q;
	logic sdo_s_q;
	logic sdi_m_q;
	logic sdi_s_q;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sdo_m_q <= 1'b0;
			sdo_s_q <= 1'b0;
			sdi_m_q <= 1'b0;
			sdi_s_q <= 1'b0;
		end
		else
		begin
			sdo_m_q <= sdo_in;
			sdo_s_q <= sdo_m_q;
			sdi_m_q <= sdi_in;
			sdi_s_q <= sdi_m_q;
		end
	end
	// ************************************************************
	// Frame sequencer
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_LOW = 3'b010,
		ST_HIGH = 3'b011,
		ST_HOLD = 3'b100,
		ST_GAP = 3'b101
	} acsp_state_t;
	acsp_state_t st_q;
	logic [7:0] tick_q;
	logic [4:0] bit_q;
	logic [15:0] sh_q;
	logic [7:0] rx_q;
	logic rd_q;
	logic [4:0] left_q;
	logic [IDLE_W-1:0] idle_q;
	logic first_q;
	logic push_q;
	logic [7:0] push_data_q;
	logic fifo_ready;
	logic tick_done;
	logic bit_in;
	logic read_phase;
	assign tick_done = (tick_q == SCK_HALF_M1);
	assign read_phase = rd_q && !first_q;
	assign bit_in = three_wire ? sdi_s_q : sdo_s_q;
	assign cmd_ready = rst_n && (st_q == ST_IDLE) && (idle_q == IDLE_ZERO);
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			tick_q <= 8'h00;
		else if (st_q == ST_IDLE || tick_done)
			tick_q <= 8'h00;
		else
			tick_q <= tick_q + 8'h01;
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= ST_IDLE;
			chip_select_n <= 1'b1;
			sck <= 1'b0;
			sdi_out <= 1'b0;
			sdi_oe <= 1'b0;
			bit_q <= BIT_ZERO;
			sh_q <= 16'h0000;
			rx_q <= 8'h00;
			rd_q <= 1'b0;
			left_q <= BIT_ZERO;
			first_q <= 1'b1;
			push_q <= 1'b0;
			push_data_q <= 8'h00;
			three_wire <= 1'b0;
			idle_q <= IDLE_ZERO;
		end
		else
		begin
			push_q <= 1'b0;
			if (idle_q != IDLE_ZERO)
				idle_q <= idle_q - 15'h0001;
			case (st_q)
				ST_IDLE:
				begin
					sck <= cpol;
					if (cmd_valid && idle_q == IDLE_ZERO)
					begin
						sh_q <= {cmd_read, cmd_addr, cmd_wdata};
						rd_q <= cmd_read;
						left_q <= (cmd_read && cmd_len != BIT_ZERO) ?
							cmd_len - 5'h01 : BIT_ZERO;
						first_q <= 1'b1;
						bit_q <= BIT_ZERO;
						if (!cmd_read && cmd_addr == ADDR_SPI_CFG)
							three_wire <= cmd_wdata[THREE_WIRE_POS];
						st_q <= ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					chip_select_n <= 1'b0;
					sdi_out <= sh_q[15];
					sdi_oe <= 1'b1;
					if (tick_done)
					begin
						// Mode 11 idles high: first low phase opens here
						sck <= 1'b0;
						st_q <= ST_LOW;
					end
				end
				ST_LOW:
				begin
					// Rising clock edge after low phase; stretch low when full
					if (tick_done &&
						!(!first_q && bit_q == BIT_ZERO && !fifo_ready))
					begin
						sck <= 1'b1;
						st_q <= ST_HIGH;
					end
				end
				ST_HIGH:
				begin
					if (tick_done)
					begin
						sck <= 1'b0;
						// Sample at end of high phase, safely after rise
						if (read_phase || (rd_q && bit_q >= 5'h08))
							rx_q <= {rx_q[6:0], bit_in};
						sh_q <= {sh_q[14:0], 1'b0};
						if (bit_q == FRAME_LAST ||
							(!first_q && bit_q == BYTE_LAST))
						begin
							if (rd_q)
							begin
								push_q <= 1'b1;
								push_data_q <= {rx_q[6:0], bit_in};
							end
							if (rd_q && left_q != BIT_ZERO)
							begin
								left_q <= left_q - 5'h01;
								first_q <= 1'b0;
								bit_q <= BIT_ZERO;
								st_q <= ST_LOW;
							end
							else
								st_q <= ST_HOLD;
						end
						else
						begin
							bit_q <= bit_q + 5'h01;
							st_q <= ST_LOW;
						end
						// Release shared pin once read data is due
						if (rd_q && (bit_q == BYTE_LAST || !first_q))
							sdi_oe <= 1'b0;
						else
							sdi_out <= sh_q[14];
					end
				end
				ST_HOLD:
				begin
					if (tick_done)
					begin
						sck <= cpol;
						chip_select_n <= 1'b1;
						sdi_oe <= 1'b0;
						st_q <= ST_GAP;
					end
				end
				ST_GAP:
				begin
					if (tick_done)
					begin
						if (!rd_q)
							idle_q <= suspend_mode ?
								IDLE_W'(WIDLE_SUSPEND) : IDLE_W'(WIDLE_NORMAL);
						st_q <= ST_IDLE;
					end
				end
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end
	// ************************************************************
	// Read data buffer
	// ************************************************************
	logic fifo_valid;
	logic [7:0] fifo_data;
	acsp_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(mclk),
		.rst_n(rst_n),
		.in_valid(push_q),
		.in_ready(fifo_ready),
		.in_data(push_data_q),
		.out_valid(fifo_valid),
		.out_ready(rd_ready && !rd_valid),
		.out_data(fifo_data)
	);
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end
		else if (rd_valid)
			rd_valid <= 1'b0;
		else if (fifo_valid && rd_ready)
		begin
			rd_valid <= 1'b1;
			rd_data <= fifo_data;
		end
	end
endmodule
`default_nettype wire

// ### tb/acsp_props.sv
// Checker for the sensor port controller
`timescale 1ns/1ps
`default_nettype none
module acsp_props(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [6:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic cpol,
	input wire logic three_wire,
	input wire logic chip_select_n,
	input wire logic sck,
	input wire logic sdi_out,
	input wire logic sdi_oe
);
	import acsp_pkg::*;
	logic s_q;
	logic [8:0] n_q;
	logic [15:0] f_q;
	logic [15:0] c_q;
	logic [7:0] k_q;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	always_ff @(posedge mclk)
	begin
		s_q <= sck;
		if (cmd_valid && cmd_ready)
			c_q <= {cmd_read, cmd_addr, cmd_wdata};
	end
	always_ff @(posedge mclk)
		if (chip_select_n)
			n_q <= 9'h000;
		else if (sck && !s_q)
		begin
			n_q <= n_q + 9'h001;
			f_q <= {f_q[14:0], sdi_out};
			if (n_q == 9'h007)
				k_q <= {f_q[6:0], sdi_out};
		end
	sequence hi4;
		sck [*4];
	endsequence
	sequence lo4;
		!sck [*4];
	endsequence
	mode_sel_a: assert property (
		$fell(chip_select_n) |-> sck == cpol) else $error("idle level");
	sck_high_a: assert property ($rose(sck) |-> hi4)
		else $error("high phase");
	sck_low_a: assert property (
		$fell(sck) && !chip_select_n |-> lo4) else $error("low phase");
	frame_len_a: assert property ($rose(chip_select_n) |->
		n_q[2:0] == 3'h0 && n_q >= 9'h010) else $error("frame length");
	wr_frame_a: assert property ($rose(chip_select_n) &&
		!c_q[15] |-> f_q == c_q) else $error("write frame");
	rd_ctl_a: assert property ($rose(chip_select_n) &&
		c_q[15] |-> k_q == c_q[15:8]) else $error("read control");
	tw_set_a: assert property ($rose(three_wire) |->
		c_q[15:8] == {DIR_WRITE, ADDR_SPI_CFG} && c_q[0])
		else $error("three wire set");
	rel_a: assert property (three_wire && c_q[15] &&
		n_q >= 9'h009 |-> !sdi_oe) else $error("pin not released");
endmodule
bind acsp_master acsp_props i_props(.*);
`default_nettype wire

// ### tb/acsp_dev.sv
// Behavioural model of the sensor serial port
`timescale 1ns/1ps
`default_nettype none
module acsp_dev(
	input wire logic chip_select_n,
	input wire logic sck,
	input wire logic sdi_in,
	output logic tw,
	output logic dout,
	output logic doe
);
	import acsp_pkg::*;
	logic [7:0] mem [128];
	logic [15:0] f;
	logic [7:0] sh;
	logic [7:0] fifo;
	logic [6:0] ra;
	logic [4:0] n;
	logic rd;
	initial
	begin
		{tw, dout, doe, rd, n} = 9'h000;
		fifo = 8'ha0;
		for (int i = 0; i < 128; i++)
			mem[i] = 8'(i) ^ 8'h55;
	end
	always @(negedge chip_select_n)
		n = 5'h00;
	always @(posedge chip_select_n)
		doe = 1'b0;
	always @(posedge sck)
		if (!chip_select_n && n != 5'h10)
		begin
			f = {f[14:0], sdi_in};
			if (n == 5'h07)
				{rd, ra} = f[7:0];
			if (n == 5'h0f && !rd)
			begin
				mem[ra] = f[7:0];
				if (ra == ADDR_SPI_CFG)
					tw = f[THREE_WIRE_POS];
			end
			n = (n == 5'h0f && rd) ? 5'h08 : n + 5'h01;
		end
	always @(negedge sck)
		if (!chip_select_n && rd && n >= 5'h08)
		begin
			if (n == 5'h08)
			begin
				sh = (ra == ADDR_FIFO_DATA) ? fifo : mem[ra];
				if (ra == ADDR_FIFO_DATA)
					fifo++;
				else
					ra++;
			end
			dout = sh[7];
			sh = {sh[6:0], 1'b0};
			doe = 1'b1;
		end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the sensor port controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import acsp_pkg::*;
	logic mclk, nrst, cmd_valid, cmd_ready, cmd_read, cpol;
	logic suspend_mode, rd_valid, rd_ready, three_wire;
	logic chip_select_n, sck, sdi_out, sdi_oe, sdi_in, sdo_in;
	logic tw, dout, doe;
	logic [6:0] cmd_addr;
	logic [7:0] cmd_wdata, rd_data;
	logic [4:0] cmd_len;
	logic [7:0] q[$];
	int error_cnt = 0;
	int checks = 0;
	acsp_master #(.WIDLE_SUSPEND(20)) i_acsp_master(.*);
	acsp_dev i_acsp_dev(.*);
	assign sdo_in = (doe && !tw) ? dout : ~dout;
	assign sdi_in = sdi_oe ? sdi_out : (doe && tw) ? dout : ~dout;
	initial
	begin
		mclk = 1'b0;
		forever
			#20 mclk = ~mclk;
	end
	always @(posedge mclk)
		if (rd_valid === 1'b1 && rd_ready)
			q.push_back(rd_data);
	initial
	begin
		#1000000;
		error_cnt++;
		complete_run;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [15:0] c, input logic [4:0] l);
		@(negedge mclk);
		{cmd_read, cmd_addr, cmd_wdata, cmd_len} = {c, l};
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1)
			@(negedge mclk);
		@(negedge mclk);
		cmd_valid = 1'b0;
	endtask
	task automatic wt(input int n);
		for (int i = 0; i < 3000 && q.size() < n; i++)
			@(posedge mclk);
	endtask
	task automatic t_modes;
		for (int m = 0; m < 2; m++)
		begin
			cpol = m[0];
			cmd({8'h10, 8'h3c + 8'(m)}, 5'h00);
			cmd(16'h9000, 5'h01);
			wt(1);
			chk(q.pop_front(), 8'h3c + 8'(m));
		end
		$display("modes done");
	endtask
	task automatic t_burst;
		for (int i = 0; i < 3; i++)
			cmd({8'h20 + 8'(i), 8'hc0 + 8'(i)}, 5'h00);
		cmd(16'ha000, 5'h03);
		wt(3);
		for (int i = 0; i < 3; i++)
			chk(q.pop_front(), 8'hc0 + 8'(i));
		rd_ready = 1'b0;
		cmd(16'hc000, 5'h0c);
		repeat (900)
			@(negedge mclk);
		rd_ready = 1'b1;
		wt(12);
		for (int i = 0; i < 12; i++)
			chk(q.pop_front(), 8'(8'h40 + i) ^ 8'h55);
		cmd(16'hbf00, 5'h03);
		wt(3);
		for (int i = 0; i < 3; i++)
			chk(q.pop_front(), 8'ha0 + 8'(i));
		$display("burst done");
	endtask
	task automatic t_gap;
		time t;
		for (int s = 0; s < 2; s++)
		begin
			suspend_mode = s[0];
			cmd(16'h3001, 5'h00);
			@(posedge chip_select_n);
			t = $time;
			fork
				cmd(16'h3102, 5'h00);
				@(negedge chip_select_n) t = $time - t;
			join
			chk({7'h00, t >= (s ? 800 : 2000)}, 8'h01);
		end
		$display("gap done");
	endtask
	task automatic t_three;
		cmd({DIR_WRITE, ADDR_SPI_CFG, 8'h01}, 5'h00);
		cmd(16'h1196, 5'h00);
		chk({7'h00, three_wire}, 8'h01);
		cmd(16'h9100, 5'h02);
		wt(2);
		chk(q.pop_front(), 8'h96);
		chk(q.pop_front(), 8'h47);
		$display("three wire done");
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		{nrst, cmd_valid, cmd_read, cpol, suspend_mode} = 5'h00;
		{cmd_addr, cmd_wdata, cmd_len} = 20'h00000;
		rd_ready = 1'b1;
		repeat (3)
			@(negedge mclk);
		nrst = 1'b1;
		t_modes;
		t_burst;
		t_gap;
		t_three;
		complete_run;
	end
endmodule
`default_nettype wire
